// *** hw/io_watchdog_relay_monitor.sv ***
// Purpose: Retriggerable timeout monitor with relay, lamps and host reset on byte I/O registers.
// Assumes: reset_in is the power-on reset; pc_reset_in is the host reset pin.
// Notes: The relay fail hold counter survives a host reset.
`timescale 1ns/1ps
`include "wdog_map.svh"
module io_watchdog_relay_monitor #(
  parameter int TICK_CYC = `TICK_CYC,
  parameter int PCRST_CYC = `PCRST_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Host I/O bus
  input wdog_pkg::io_req_t io_req_in,
  output logic [7:0] rd_data_out,
  // Pins from outside
  input wire logic pc_reset_in,
  input wire logic over_temp_in,
  // Outputs
  output logic relay_out,
  output logic activity_lamp_green_out,
  output logic activity_lamp_red_out,
  output logic software_lamp_out,
  output logic pc_reset_out,
  output logic irq_out
);
  import wdog_pkg::*;

  if (TICK_CYC < 2 || PCRST_CYC < 1)
  begin : bad_param
    $error("TICK_CYC must be at least 2 and PCRST_CYC at least 1");
  end

  // period select to count of time base ticks
  function automatic logic [`CNT_W-1:0] period_ms(input logic [1:0] sel);
    case (sel)
      2'b00: period_ms = `CNT_W'(`PER0_MS);
      2'b01: period_ms = `CNT_W'(`PER1_MS);
      2'b10: period_ms = `CNT_W'(`PER2_MS);
      default: period_ms = `CNT_W'(`PER3_MS);
    endcase
  endfunction

  logic [1:0] pins_s;
  logic pc_rst_s;
  logic temp_s;
  logic wd_rst;
  wd_state_t state_q;
  logic [`CNT_W-1:0] cnt_q;
  logic [$clog2(TICK_CYC)-1:0] pre_q;
  logic tick;
  logic [7:0] conf_q;
  logic relay_en_q;
  logic [9:0] hold_q;
  logic [$clog2(PCRST_CYC+1)-1:0] prst_q;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_conf;
  logic rd_stat;
  logic [1:0] new_sel;
  logic restart;
  logic expire;
  logic temp_fail;

  pin_sync3 #(
    .W(2)
  ) u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pin_in({pc_reset_in, over_temp_in}),
    .level_out(pins_s)
  );

  // Decodes and events
  assign pc_rst_s = pins_s[1];
  assign temp_s = pins_s[0];
  assign wd_rst = reset_in | pc_rst_s;
  assign wr_ctrl = io_req_in.wr && io_req_in.addr == `OFS_CTRL;
  assign wr_stat = io_req_in.wr && io_req_in.addr == `OFS_STAT;
  assign wr_conf = io_req_in.wr && io_req_in.addr == `OFS_CONF;
  assign rd_stat = io_req_in.rd && io_req_in.addr == `OFS_STAT;
  assign new_sel = {io_req_in.data[`CONF_PER_HI], io_req_in.data[`CONF_PER_LO]};
  assign restart = wr_stat || (wr_conf && state_q == WD_RUN &&
                   new_sel != {conf_q[`CONF_PER_HI], conf_q[`CONF_PER_LO]});
  assign expire = state_q == WD_RUN && tick && cnt_q == `CNT_W'(1) && !restart;
  assign temp_fail = temp_s && conf_q[`CONF_TEMP_EN];

  always_ff @(posedge clk_in)
  begin
    if (wd_rst || restart || pre_q == TICK_CYC - 1)
      pre_q <= '0;
    else
      pre_q <= pre_q + 1'b1;
  end
  assign tick = pre_q == TICK_CYC - 1;

  always_ff @(posedge clk_in)
  begin
    if (wd_rst)
      conf_q <= `CONF_RESET;
    else if (wr_conf)
      conf_q <= io_req_in.data;
  end

  always_ff @(posedge clk_in)
  begin
    if (wd_rst)
    begin
      state_q <= WD_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        WD_IDLE:
        begin
          if (wr_stat)
          begin
            state_q <= WD_RUN;
            cnt_q <= period_ms({conf_q[`CONF_PER_HI], conf_q[`CONF_PER_LO]});
          end
        end
        WD_RUN:
        begin
          if (restart)
            cnt_q <= period_ms(wr_conf ? new_sel :
                               {conf_q[`CONF_PER_HI], conf_q[`CONF_PER_LO]});
          else if (expire)
            state_q <= WD_EXPIRED;
          else if (tick)
            cnt_q <= cnt_q - 1'b1;
        end
        WD_EXPIRED:
        begin
          if (wr_stat)
          begin
            state_q <= WD_RUN;
            cnt_q <= period_ms({conf_q[`CONF_PER_HI], conf_q[`CONF_PER_LO]});
          end
        end
        default:
          state_q <= WD_IDLE;
      endcase
    end
  end

  // fail hold, kept through a host reset
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      hold_q <= '0;
    else if (expire || temp_fail)
      hold_q <= 10'(`HOLD_MS + 1);
    else if (tick && hold_q != '0)
      hold_q <= hold_q - 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (wd_rst)
      relay_en_q <= 1'b1;
    else if (wr_ctrl)
      relay_en_q <= io_req_in.data[`CTRL_RELAY];
  end

  // relay drops in any fail state
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      relay_out <= 1'b0;
    else
      relay_out <= relay_en_q && state_q != WD_EXPIRED && !temp_fail && hold_q == '0;
  end

  always_ff @(posedge clk_in)
  begin
    if (wd_rst)
      software_lamp_out <= 1'b0;
    else if (wr_ctrl)
      software_lamp_out <= io_req_in.data[`CTRL_SWLAMP];
  end

  // host reset pulse, by request or enabled expiry
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      prst_q <= '0;
    else if ((wr_ctrl && io_req_in.data[`CTRL_PCRST]) || (expire && conf_q[`CONF_RST_EN]))
      prst_q <= ($bits(prst_q))'(PCRST_CYC);
    else if (prst_q != '0)
      prst_q <= prst_q - 1'b1;
  end

  // Reset pin driven from its own flop
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      pc_reset_out <= 1'b0;
    else
      pc_reset_out <= prst_q != '0;
  end

  always_ff @(posedge clk_in)
  begin
    if (wd_rst || wr_stat)
      irq_out <= 1'b0;
    else if (expire && conf_q[`CONF_IRQ_EN])
      irq_out <= 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (wd_rst)
    begin
      activity_lamp_green_out <= 1'b0;
      activity_lamp_red_out <= 1'b0;
    end
    else
    begin
      activity_lamp_green_out <= state_q == WD_RUN;
      activity_lamp_red_out <= state_q == WD_EXPIRED;
    end
  end

  // status read; other offsets read zero
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      rd_data_out <= 8'h00;
    else if (rd_stat)
    begin
      rd_data_out <= 8'h00;
      rd_data_out[`STAT_WD] <= state_q != WD_EXPIRED;
      rd_data_out[`STAT_TEMP] <= !temp_s;
    end
    else if (io_req_in.rd)
      rd_data_out <= 8'h00;
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (wd_rst);

  stat_read_wd_a: assert property (rd_stat |=> rd_data_out[`STAT_WD] == $past(state_q != WD_EXPIRED))
    else $error("status bit does not follow monitor");
  idle_reads_one_a: assert property (rd_stat && state_q == WD_IDLE |=> rd_data_out[`STAT_WD])
    else $error("idle monitor reads zero");
  relay_off_a: assert property (wr_ctrl && !io_req_in.data[`CTRL_RELAY] |=> ##1 !relay_out)
    else $error("relay not dropped by control write");
  sw_lamp_a: assert property (wr_ctrl |=> software_lamp_out == $past(io_req_in.data[`CTRL_SWLAMP]))
    else $error("software lamp not set");
  arm_green_a: assert property (state_q == WD_IDLE && wr_stat |=> state_q == WD_RUN ##1 activity_lamp_green_out)
    else $error("first trigger did not arm");
  retrig_full_a: assert property (state_q == WD_RUN && wr_stat |=> cnt_q == period_ms({conf_q[`CONF_PER_HI], conf_q[`CONF_PER_LO]}) && pre_q == '0)
    else $error("retrigger did not reload");
  rearm_exp_a: assert property (state_q == WD_EXPIRED && wr_stat |=> state_q == WD_RUN ##1 activity_lamp_green_out && !irq_out)
    else $error("expired monitor not restarted");
  per_change_a: assert property (state_q == WD_RUN && wr_conf && new_sel != {conf_q[`CONF_PER_HI], conf_q[`CONF_PER_LO]} |=> cnt_q == period_ms($past(new_sel)))
    else $error("period change did not restart");
  idle_dark_a: assert property (state_q == WD_IDLE |=> !activity_lamp_green_out && !activity_lamp_red_out)
    else $error("lamp lit while idle");
  decode_16s_a: assert property (state_q == WD_IDLE && wr_stat && conf_q[`CONF_PER_HI] && conf_q[`CONF_PER_LO] |=> cnt_q == `CNT_W'(`PER3_MS))
    else $error("longest period wrong");
  expire_red_a: assert property (expire |=> state_q == WD_EXPIRED ##1 activity_lamp_red_out && !relay_out)
    else $error("expiry reaction missing");
  hold_load_a: assert property (expire |=> hold_q == 10'(`HOLD_MS + 1))
    else $error("fail hold not loaded");
  tick_gap_a: assert property (tick |=> !tick)
    else $error("prescaler ticks too fast");
endmodule

// *** hw/pin_sync3.sv ***
// Purpose: Brings asynchronous pins onto clk_in.
// Assumes: Pins change slowly compared with the clock.
// Notes: A change counts once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 2
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Pins and result
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level_out
);
  // Refuse an empty pin group
  if (W < 1)
  begin : bad_width
    $error("W must be at least 1");
  end

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Three stages; the first is read only by the second
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept bits on which the late stages agree
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
      level_out <= '0;
    else
      level_out <= (s2_q & s3_q) | (level_out & (s2_q | s3_q));
  end
endmodule

// *** hw/wdog_map.svh ***
// Purpose: Offsets, field positions, reset values and timing figures of the monitor.
// Assumes: Byte-wide I/O registers addressed by the low address nibble.
// Notes: Times are in their own unit; cycle counts are derived from the clock rate.
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH
`define OFS_CTRL 4'hd
`define OFS_STAT 4'he
`define OFS_CONF 4'hf
`define CTRL_SWLAMP 2
`define CTRL_RELAY 1
`define CTRL_PCRST 7
`define STAT_TEMP 0
`define STAT_WD 1
`define CONF_PER_HI 3
`define CONF_PER_LO 4
`define CONF_TEMP_EN 5
`define CONF_RST_EN 6
`define CONF_IRQ_EN 7
`define CONF_RESET 8'h00
`define CTRL_RESET 8'h02
`define CLK_MHZ 125
`define TICK_MS 1
`define TICK_CYC (`CLK_MHZ * 1000 * `TICK_MS)
`define PER0_MS 1000
`define PER1_MS 2000
`define PER2_MS 8000
`define PER3_MS 16000
`define HOLD_MS 500
`define PCRST_US 10
`define PCRST_CYC (`PCRST_US * `CLK_MHZ)
`define CNT_W 14
`endif

// *** hw/wdog_pkg.sv ***
// Purpose: Types shared by the monitor files.
// Assumes: The I/O bus strobes are already on clk_in.
// Notes: Offsets and figures live in the map header.
package wdog_pkg;
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] data;
  } io_req_t;
  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_RUN = 3'b010,
    WD_EXPIRED = 3'b100
  } wd_state_t;
endpackage

// *** sim/host_bus_model.sv ***
// Purpose: Host processor side of the byte I/O bus and of the host reset line.
// Assumes: One transfer per call, driven just after a rising edge.
// Notes: Released data lines show the inverse of the last value.
`timescale 1ns/1ps
module host_bus_model (
  // Clock and reset request
  input wire logic clk_in,
  input wire logic rst_req_in,
  // Bus
  input wire logic [7:0] rd_data_in,
  output wdog_pkg::io_req_t io_req_out,
  output logic host_reset_out
);
  import wdog_pkg::*;
  // Host reset controller follows the request line
  assign host_reset_out = rst_req_in;
  initial io_req_out = '0;
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 io_req_out = '{addr: a, wr: 1'b1, rd: 1'b0, data: d};
    @(posedge clk_in);
    #1 io_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, data: ~d};
  endtask
  // Read cycle, data taken one edge after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1 io_req_out = '{addr: a, wr: 1'b0, rd: 1'b1, data: 8'h5a};
    @(posedge clk_in);
    #1 io_req_out = '{addr: ~a, wr: 1'b0, rd: 1'b0, data: 8'ha5};
    @(posedge clk_in);
    #1 d = rd_data_in;
  endtask
endmodule

// *** sim/io_watchdog_relay_monitor_test.sv ***
// Purpose: Self-checking run of the timeout monitor through its I/O registers.
// Assumes: Prescaler of 4 cycles per tick and a 3 cycle host reset pulse.
// Notes: Expiry times are counted from the write that restarts the count.
`timescale 1ns/1ps
`include "wdog_map.svh"
module io_watchdog_relay_monitor_test;
  import wdog_pkg::*;
  logic clk_in;
  logic reset_in;
  logic over_temp_in;
  logic pc_reset_in;
  logic relay_out;
  logic green;
  logic red;
  logic sw_lamp;
  logic pc_reset_out;
  logic irq_out;
  logic [7:0] rd_data_out;
  logic [7:0] rv;
  io_req_t io_req;
  int err_count;
  int tests_run;
  int n;
  int per[3];

  // Design with shortened counts
  io_watchdog_relay_monitor #(.TICK_CYC(4), .PCRST_CYC(3)) DUT (
    .clk_in(clk_in), .reset_in(reset_in), .io_req_in(io_req), .rd_data_out(rd_data_out),
    .pc_reset_in(pc_reset_in), .over_temp_in(over_temp_in), .relay_out(relay_out),
    .activity_lamp_green_out(green), .activity_lamp_red_out(red),
    .software_lamp_out(sw_lamp), .pc_reset_out(pc_reset_out), .irq_out(irq_out)
  );

  // Host side
  host_bus_model HOST (
    .clk_in(clk_in), .rst_req_in(pc_reset_out), .rd_data_in(rd_data_out),
    .io_req_out(io_req), .host_reset_out(pc_reset_in)
  );

  // Clock at 125 MHz
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic step(input int c);
    repeat (c) @(posedge clk_in);
    #1;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t output %b expected %b", $time, got, exp);
    end
  endtask

  function automatic logic sel_sig(input int s);
    case (s)
      0: return red;
      1: return relay_out;
      default: return pc_reset_out;
    endcase
  endfunction

  // Bounded wait for an output to go high
  task automatic wait_for(input int s, input int lim, output int cnt);
    cnt = 0;
    while (sel_sig(s) !== 1'b1)
    begin
      if (cnt == lim)
      begin
        err_count++;
        $display("[ERR] %0t wait %0d ran out", $time, s);
        tally_and_finish();
      end
      step(1);
      cnt++;
    end
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    per = '{`PER0_MS, `PER1_MS, `PER2_MS};
    err_count = 0;
    tests_run = 0;
    over_temp_in = 1'b0;
    reset_in = 1'b1;
    step(20);
    reset_in = 1'b0;
    step(4);
    chk_bit(green, 1'b0);
    chk_bit(red, 1'b0);
    chk_bit(relay_out, 1'b1);
    HOST.rd(`OFS_STAT, rv);
    chk_byte(rv, 8'h03);
    end_test("reset");
    HOST.wr(`OFS_CTRL, 8'h04);
    step(2);
    chk_bit(relay_out, 1'b0);
    chk_bit(sw_lamp, 1'b1);
    HOST.wr(`OFS_CTRL, 8'h02);
    step(2);
    chk_bit(relay_out, 1'b1);
    chk_bit(sw_lamp, 1'b0);
    HOST.rd(`OFS_CTRL, rv);
    chk_byte(rv, 8'h00);
    HOST.wr(`OFS_CTRL, 8'h82);
    wait_for(2, 10, n);
    step(10);
    end_test("control");
    HOST.wr(`OFS_CONF, 8'h00);
    HOST.wr(`OFS_STAT, 8'h00);
    step(2);
    chk_bit(green, 1'b1);
    step(3900);
    HOST.wr(`OFS_STAT, 8'h00);
    step(3900);
    chk_bit(red, 1'b0);
    wait_for(0, 300, n);
    HOST.rd(`OFS_STAT, rv);
    chk_byte(rv, 8'h01);
    chk_bit(relay_out, 1'b0);
    chk_bit(pc_reset_out | irq_out, 1'b0);
    HOST.wr(`OFS_STAT, 8'h00);
    step(2);
    chk_bit(green & ~red, 1'b1);
    chk_bit(relay_out, 1'b0);
    wait_for(1, 2100, n);
    chk_bit(n >= 1900, 1'b1);
    end_test("expiry");
    for (int c = 0; c < 3; c++)
    begin
      HOST.wr(`OFS_STAT, 8'h00);
      HOST.wr(`OFS_CONF, {3'b000, c[0], c[1], 3'b000});
      wait_for(0, 70000, n);
      chk_bit(n >= per[c] * 4 - 8 && n <= per[c] * 4 + 8, 1'b1);
    end
    end_test("periods");
    HOST.wr(`OFS_STAT, 8'h00);
    HOST.wr(`OFS_CONF, 8'h80);
    wait_for(0, 4100, n);
    step(2);
    chk_bit(irq_out, 1'b1);
    HOST.wr(`OFS_STAT, 8'h00);
    step(2);
    chk_bit(irq_out, 1'b0);
    HOST.wr(`OFS_CONF, 8'h40);
    wait_for(0, 4100, n);
    wait_for(2, 10, n);
    step(20);
    HOST.rd(`OFS_STAT, rv);
    chk_byte(rv, 8'h03);
    chk_bit(green, 1'b0);
    chk_bit(relay_out, 1'b0);
    end_test("options");
    HOST.wr(`OFS_CONF, 8'h38);
    HOST.wr(`OFS_STAT, 8'h00);
    step(2);
    chk_bit(green, 1'b1);
    over_temp_in = 1'b1;
    step(8);
    HOST.rd(`OFS_STAT, rv);
    chk_byte(rv, 8'h02);
    over_temp_in = 1'b0;
    end_test("temperature");
    tally_and_finish();
  end
endmodule
